// file: src/mszcfg_defs.vh
// constants for the memory size configuration register bank
`ifndef MSZCFG_DEFS_VH
`define MSZCFG_DEFS_VH
// ****************************************
// register addresses
// ****************************************
`define MSZCFG_ADDR_MEM_SIZE 16'hFFF0
`define MSZCFG_ADDR_EXT_SIZE 16'hFFF4
// ****************************************
// reset values
// ****************************************
`define MSZCFG_RST_MEM_SIZE 8'hCF
`define MSZCFG_RST_EXT_SIZE 8'h0C
// ****************************************
// field positions and writable masks
// ****************************************
`define MSZCFG_HS_RAM_MSB 7
`define MSZCFG_HS_RAM_LSB 5
`define MSZCFG_ROM_MSB 3
`define MSZCFG_ROM_LSB 0
`define MSZCFG_EXT_MSB 4
`define MSZCFG_EXT_LSB 0
`define MSZCFG_MASK_MEM_SIZE 8'hEF
`define MSZCFG_MASK_EXT_SIZE 8'h1F
// ****************************************
// legal field codes
// ****************************************
`define MSZCFG_HS_RAM_1K 3'h6
`define MSZCFG_ROM_48K 4'hC
`define MSZCFG_ROM_60K 4'hF
`define MSZCFG_EXT_RAM_1K 5'h0A
// ****************************************
// capacities in bytes for the unused-region decode
// ****************************************
`define MSZCFG_HS_RAM_BYTES 17'h00400
`define MSZCFG_ROM_48K_BYTES 17'h0C000
`define MSZCFG_ROM_60K_BYTES 17'h0F000
`define MSZCFG_EXT_RAM_BYTES 17'h00400
`endif

// file: src/mszcfg_reg8.v
// one 8-bit configuration register with a fixed-zero mask
`timescale 1ns/100ps
module mszcfg_reg8 #(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WR_MASK = 8'hFF
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // write port
  input wire wr_en,
  input wire [7:0] wr_data,
  // stored value
  output wire [7:0] value
);
  reg [7:0] value_reg;
  // ****************************************
  // storage
  // ****************************************
  // prohibited patterns are stored unchanged; decode treats them as unmatched
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value_reg <= RESET_VAL;
    end else if (wr_en) begin
      value_reg <= wr_data & WR_MASK;
    end
  end
  assign value = value_reg;
endmodule

// file: src/mszcfg_regs.v
// memory size configuration registers on the cpu 8-bit memory bus
//
// Notes on behaviour
// - memory size select lives at FFF0, read/write, 8-bit accesses only.
// - reset loads memory size select with CF: 1024-byte RAM, 60 KB ROM.
// - memory beyond selected capacities is flagged unused, matching mask versions.
// - bits 7..5 pick high-speed RAM size; only 110 (1024 bytes) is legal.
// - bits 3..0 pick ROM size; 1100 is 48 KB, 1111 is 60 KB.
// - expansion RAM size select lives at FFF4, read/write, bits 7..5 zero.
// - reset loads expansion RAM size select with 0C.
// - bits 4..0 pick expansion RAM size; only 01010 (1024 bytes) is legal.
`timescale 1ns/100ps
`include "mszcfg_defs.vh"
module mszcfg_regs (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // cpu memory access, 8 bits wide
  input wire [15:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire [7:0] cpu_wdata,
  output reg [7:0] cpu_rdata,
  output wire cpu_hit,
  // memory map probe from the cpu fetch/data path
  input wire [16:0] probe_rom_offset,
  input wire [16:0] probe_hs_ram_offset,
  input wire [16:0] probe_ext_ram_offset,
  // decoded configuration
  output wire [7:0] memory_size_select,
  output wire [7:0] expansion_ram_size_select,
  output wire rom_is_48k,
  output wire rom_size_legal,
  output wire hs_ram_size_legal,
  output wire ext_ram_size_legal,
  output wire [16:0] rom_bytes,
  output wire rom_unused,
  output wire hs_ram_unused,
  output wire ext_ram_unused
);
  // ****************************************
  // sizes and per-entry tables
  // ****************************************
  // bus and offset widths
  localparam ADDR_W = 16;
  localparam DATA_W = 8;
  localparam OFFS_W = 17;

  // field widths follow the field positions
  localparam HS_W = `MSZCFG_HS_RAM_MSB - `MSZCFG_HS_RAM_LSB + 1;
  localparam ROM_W = `MSZCFG_ROM_MSB - `MSZCFG_ROM_LSB + 1;
  localparam EXT_W = `MSZCFG_EXT_MSB - `MSZCFG_EXT_LSB + 1;

  // entry and region numbering
  localparam N_REGS = 2;
  localparam IDX_MEM = 0;
  localparam IDX_EXT = 1;
  localparam N_REGIONS = 3;
  localparam REGION_ROM = 0;
  localparam REGION_HS = 1;
  localparam REGION_EXT = 2;

  // per-entry tables, entry 0 in the low bits
  localparam [N_REGS*ADDR_W-1:0] REG_ADDRS = {
    `MSZCFG_ADDR_EXT_SIZE, // entry 1
    `MSZCFG_ADDR_MEM_SIZE // entry 0
  };
  localparam [N_REGS*DATA_W-1:0] REG_RESETS = {
    `MSZCFG_RST_EXT_SIZE, // entry 1
    `MSZCFG_RST_MEM_SIZE // entry 0
  };

  // masks clear the fixed-zero positions before storage
  localparam [N_REGS*DATA_W-1:0] REG_MASKS = {
    `MSZCFG_MASK_EXT_SIZE, // entry 1
    `MSZCFG_MASK_MEM_SIZE // entry 0
  };

  // ****************************************
  // internal nets
  // ****************************************
  // per-entry decode and storage
  wire [N_REGS-1:0] sel;
  wire [N_REGS-1:0] wr_hit;
  wire [N_REGS-1:0] rd_hit;
  wire [N_REGS*DATA_W-1:0] reg_values;
  wire [(N_REGS+1)*DATA_W-1:0] rd_chain;

  // single bits of the memory size select register
  wire hs_ram_size_bit2;
  wire hs_ram_size_bit1;
  wire hs_ram_size_bit0;
  wire program_store_size_bit3;
  wire program_store_size_bit2;
  wire program_store_size_bit1;
  wire program_store_size_bit0;

  // single bits of the expansion ram size select register
  wire ext_ram_size_bit4;
  wire ext_ram_size_bit3;
  wire ext_ram_size_bit2;
  wire ext_ram_size_bit1;
  wire ext_ram_size_bit0;

  // field views and their decodes
  wire [HS_W-1:0] hs_ram_field;
  wire [ROM_W-1:0] rom_field;
  wire [EXT_W-1:0] ext_field;
  wire rom_is_60k;

  // per-region probe offsets and capacities
  wire [N_REGIONS*OFFS_W-1:0] probe_offsets;
  wire [N_REGIONS*OFFS_W-1:0] region_limits;
  wire [N_REGIONS-1:0] region_unused;

  // ****************************************
  // register entries
  // ****************************************
  // one generate loop builds match, storage and read term per entry
  genvar g;
  generate
    for (g = 0; g < N_REGS; g = g + 1) begin : g_entry
      // exact byte match; neighbours such as FFF2 fall through unanswered
      assign sel[g] = (cpu_addr == REG_ADDRS[g*ADDR_W +: ADDR_W]);
      assign wr_hit[g] = cpu_wr & sel[g];
      assign rd_hit[g] = cpu_rd & sel[g];
      // masked storage: fixed-zero bits never leave zero
      mszcfg_reg8 #(
        .RESET_VAL(REG_RESETS[g*DATA_W +: DATA_W]),
        .WR_MASK(REG_MASKS[g*DATA_W +: DATA_W])
      ) u_reg (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(wr_hit[g]),
        .wr_data(cpu_wdata),
        .value(reg_values[g*DATA_W +: DATA_W])
      );
      // or-chain of read terms; addresses are distinct, so at most one term is live
      assign rd_chain[(g+1)*DATA_W +: DATA_W] = rd_chain[g*DATA_W +: DATA_W] |
        (rd_hit[g] ? reg_values[g*DATA_W +: DATA_W] : {DATA_W{1'b0}});
    end
  endgenerate

  // ****************************************
  // cpu bus answers
  // ****************************************
  // chain starts at zero so a miss reads as 00 on a wired-or data bus
  assign rd_chain[DATA_W-1:0] = {DATA_W{1'b0}};
  // hit tells the bus this block answers; it never gates storage
  assign cpu_hit = (|sel) & (cpu_rd | cpu_wr);
  // a read in the same cycle as a write still shows the old value
  always @* begin
    cpu_rdata = rd_chain[N_REGS*DATA_W +: DATA_W];
  end
  // register values straight from the flops
  assign memory_size_select = reg_values[IDX_MEM*DATA_W +: DATA_W];
  assign expansion_ram_size_select = reg_values[IDX_EXT*DATA_W +: DATA_W];

  // ****************************************
  // field bits
  // ****************************************
  // high-speed ram size, bits 7..5
  assign hs_ram_size_bit2 = memory_size_select[`MSZCFG_HS_RAM_MSB];
  assign hs_ram_size_bit1 = memory_size_select[`MSZCFG_HS_RAM_MSB-1];
  assign hs_ram_size_bit0 = memory_size_select[`MSZCFG_HS_RAM_LSB];
  // program store size, bits 3..0
  assign program_store_size_bit3 = memory_size_select[`MSZCFG_ROM_MSB];
  assign program_store_size_bit2 = memory_size_select[`MSZCFG_ROM_MSB-1];
  assign program_store_size_bit1 = memory_size_select[`MSZCFG_ROM_LSB+1];
  assign program_store_size_bit0 = memory_size_select[`MSZCFG_ROM_LSB];
  // expansion ram size, bits 4..0
  assign ext_ram_size_bit4 = expansion_ram_size_select[`MSZCFG_EXT_MSB];
  assign ext_ram_size_bit3 = expansion_ram_size_select[`MSZCFG_EXT_MSB-1];
  assign ext_ram_size_bit2 = expansion_ram_size_select[`MSZCFG_EXT_LSB+2];
  assign ext_ram_size_bit1 = expansion_ram_size_select[`MSZCFG_EXT_LSB+1];
  assign ext_ram_size_bit0 = expansion_ram_size_select[`MSZCFG_EXT_LSB];
  // fields rebuilt msb first
  assign hs_ram_field = {hs_ram_size_bit2, hs_ram_size_bit1, hs_ram_size_bit0};
  assign rom_field = {program_store_size_bit3, program_store_size_bit2,
    program_store_size_bit1, program_store_size_bit0};
  assign ext_field = {ext_ram_size_bit4, ext_ram_size_bit3, ext_ram_size_bit2,
    ext_ram_size_bit1, ext_ram_size_bit0};

  // ****************************************
  // field decode
  // ****************************************
  // prohibited codes are only flagged; storage keeps them as written
  assign hs_ram_size_legal = (hs_ram_field == `MSZCFG_HS_RAM_1K);
  assign rom_is_48k = (rom_field == `MSZCFG_ROM_48K);
  assign rom_is_60k = (rom_field == `MSZCFG_ROM_60K);
  assign rom_size_legal = rom_is_48k | rom_is_60k;
  // the reset code reads back as illegal until software writes 0A
  assign ext_ram_size_legal = (ext_field == `MSZCFG_EXT_RAM_1K);

  // ****************************************
  // unused-region flags
  // ****************************************
  // prohibited rom codes fall back to the full size; their real decode is undefined
  assign rom_bytes = rom_is_48k ? `MSZCFG_ROM_48K_BYTES : `MSZCFG_ROM_60K_BYTES;
  // region packing, rom in the low bits
  assign probe_offsets = {
    probe_ext_ram_offset, // region 2
    probe_hs_ram_offset, // region 1
    probe_rom_offset // region 0
  };
  // both rams have one legal size, so their limits are fixed
  assign region_limits = {
    `MSZCFG_EXT_RAM_BYTES, // region 2
    `MSZCFG_HS_RAM_BYTES, // region 1
    rom_bytes // region 0
  };
  // one compare per region; offsets at or past the limit are unused
  genvar r;
  generate
    for (r = 0; r < N_REGIONS; r = r + 1) begin : g_region
      assign region_unused[r] = (probe_offsets[r*OFFS_W +: OFFS_W] >=
        region_limits[r*OFFS_W +: OFFS_W]);
    end
  endgenerate
  // flags by region
  assign rom_unused = region_unused[REGION_ROM];
  assign hs_ram_unused = region_unused[REGION_HS];
  assign ext_ram_unused = region_unused[REGION_EXT];
endmodule

// file: verif/mszcfg_chk.sv
// checker for the memory size configuration registers
`timescale 1ns/100ps
module mszcfg_chk (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // cpu access
  input wire [15:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire [7:0] cpu_wdata,
  input wire [7:0] cpu_rdata,
  // register values
  input wire [7:0] memory_size_select,
  input wire [7:0] expansion_ram_size_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // address decode helpers, shared by several properties
  wire at_m = cpu_addr == 16'hFFF0;
  wire at_x = cpu_addr == 16'hFFF4;
  property p_wr_m; cpu_wr && at_m |=> memory_size_select == ($past(cpu_wdata) & 8'hEF); endproperty
  a_wr_m: assert property (p_wr_m) else $error("mem select write");
  property p_wr_x; cpu_wr && at_x |=> expansion_ram_size_select == ($past(cpu_wdata) & 8'h1F); endproperty
  a_wr_x: assert property (p_wr_x) else $error("ext select write");
  property p_keep_m; !(cpu_wr && at_m) |=> $stable(memory_size_select); endproperty
  a_keep_m: assert property (p_keep_m) else $error("mem select moved");
  property p_rd_m; cpu_rd && at_m |-> cpu_rdata == memory_size_select; endproperty
  a_rd_m: assert property (p_rd_m) else $error("mem select read");
  property p_rd_x; cpu_rd && at_x |-> cpu_rdata == expansion_ram_size_select; endproperty
  a_rd_x: assert property (p_rd_x) else $error("ext select read");
  property p_zero; memory_size_select[4] == 1'b0 && expansion_ram_size_select[7:5] == 3'h0; endproperty
  a_zero: assert property (p_zero) else $error("fixed bit set");
  property p_rst_m; $rose(arst_n) |-> memory_size_select == 8'hCF; endproperty
  a_rst_m: assert property (p_rst_m) else $error("mem reset value");
  property p_rst_x; $rose(arst_n) |-> expansion_ram_size_select == 8'h0C; endproperty
  a_rst_x: assert property (p_rst_x) else $error("ext reset value");
  // main scenarios
  c_wr_x: cover property (cpu_wr && at_x);
  c_rd_m: cover property (cpu_rd && at_m);
  c_rst: cover property ($rose(arst_n));
endmodule
bind mszcfg_regs mszcfg_chk u_chk (.clk(clk), .arst_n(arst_n), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
  .memory_size_select(memory_size_select), .expansion_ram_size_select(expansion_ram_size_select));

// file: verif/tb_mszcfg_regs.sv
// self-checking bench for the memory size configuration registers
`timescale 1ns/100ps
module tb_mszcfg_regs;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg [15:0] cpu_addr = 16'h0000;
  reg cpu_wr = 1'b0;
  reg cpu_rd = 1'b0;
  reg [7:0] cpu_wdata = 8'h00;
  wire [7:0] cpu_rdata;
  wire [7:0] mss;
  wire [7:0] xss;
  wire is48;
  wire hit;
  wire rom_ok;
  wire hs_ok;
  wire ext_ok;
  wire [16:0] rbytes;
  wire rom_un;
  wire hs_un;
  wire ext_un;
  reg [16:0] p_rom = 17'h00000;
  reg [16:0] p_hs = 17'h00000;
  reg [16:0] p_ext = 17'h00000;
  integer n_errors = 0;
  integer checked = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] rows [0:7];
  always #20 clk = ~clk;
  // probes sweep the region edges in the hand-written cases
  mszcfg_regs DUT (.clk(clk), .arst_n(arst_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_hit(hit),
    .probe_rom_offset(p_rom), .probe_hs_ram_offset(p_hs),
    .probe_ext_ram_offset(p_ext), .memory_size_select(mss),
    .expansion_ram_size_select(xss), .rom_is_48k(is48), .rom_size_legal(rom_ok),
    .hs_ram_size_legal(hs_ok), .ext_ram_size_legal(ext_ok), .rom_bytes(rbytes),
    .rom_unused(rom_un), .hs_ram_unused(hs_un), .ext_ram_unused(ext_un));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // strobes drop on the next falling edge, so calls never collide
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(negedge clk);
      cpu_wr = 1'b1;
      cpu_addr = a;
      cpu_wdata = d;
      @(negedge clk);
      cpu_wr = 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(negedge clk);
      cpu_rd = 1'b1;
      cpu_addr = a;
      #1 chk(cpu_rdata, e);
      chk({7'h00, hit}, {7'h00, (a == 16'hFFF0) | (a == 16'hFFF4)});
      @(negedge clk);
      cpu_rd = 1'b0;
    end
  endtask
  // set the three probe offsets, then compare the flags {rom, hs ram, ext ram}
  task probe(input [16:0] r, input [16:0] h, input [16:0] x, input [7:0] e);
    begin
      @(negedge clk);
      p_rom = r;
      p_hs = h;
      p_ext = x;
      #1 chk({5'h00, rom_un, hs_un, ext_un}, e);
    end
  endtask
  task wrap_up;
    begin
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // hang guard, far above the few dozen cycles needed
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  initial begin
    // address, write data, expected read-back
    rows[0] = 32'hFFF0_CC_CC;
    rows[1] = 32'hFFF0_FF_EF;
    rows[2] = 32'hFFF0_00_00;
    rows[3] = 32'hFFF0_CF_CF;
    rows[4] = 32'hFFF4_0A_0A;
    rows[5] = 32'hFFF4_FF_1F;
    rows[6] = 32'hFFF4_15_15;
    rows[7] = 32'hFFF2_55_00;
    repeat (12) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    rd(16'hFFF0, 8'hCF);
    rd(16'hFFF4, 8'h0C);
    chk({5'h00, hs_ok, rom_ok, ext_ok}, 8'h06);
    for (i = 0; i < 8; i = i + 1) begin
      wr(rows[i][31:16], rows[i][15:8]);
      rd(rows[i][31:16], rows[i][7:0]);
    end
    // the stray write to FFF2 must leave both registers alone
    chk(mss, 8'hCF);
    chk(xss, 8'h15);
    chk({5'h00, hs_ok, rom_ok, ext_ok}, 8'h06);
    chk(rbytes[15:8], 8'hF0);
    probe(17'h0EFFF, 17'h003FF, 17'h003FF, 8'h00);
    probe(17'h0F000, 17'h00400, 17'h00400, 8'h07);
    wr(16'hFFF0, 8'hCC);
    chk({7'h00, is48}, 8'h01);
    chk(rbytes[15:8], 8'hC0);
    probe(17'h0BFFF, 17'h003FF, 17'h003FF, 8'h00);
    probe(17'h0C000, 17'h003FF, 17'h003FF, 8'h04);
    @(negedge clk) arst_n = 1'b0;
    #1 chk(mss, 8'hCF);
    chk(xss, 8'h0C);
    @(negedge clk) arst_n = 1'b1;
    rd(16'hFFF4, 8'h0C);
    wr(16'hFFF4, 8'h0A);
    chk({7'h00, ext_ok}, 8'h01);
    wrap_up;
  end
endmodule
